// [ibcc_pkg.sv]
// Behaviour
// - backplane addresses are integers 0 to 127, unique, by physical position
// - the network interface unit always holds backplane address 127
// - only addresses 1 to 12 go to addressable I/O modules
// - modules are numbered consecutively left to right after the interface unit
// - address assignment runs on every power-up and every backplane reset
// - power distribution modules, empty bases, termination plate get no address
// - auto configuration runs on first power-up and on valid button request
// - auto configuration checks each module connection and stores defaults in nvm
// - reconfiguration starts only after button held two seconds continuously
// - button ignored until one configuration has completed successfully
// - reconfigure: re-address and derive defaults, write nvm, re-initialise backplane
// - reconfiguration never touches fieldbus baud rate or node identifier
// - on fallback every output channel is driven to zero
// - fallback values are fixed; nothing can change them
// - loss of fieldbus master communication forces fallback
// - missing heartbeat from unit or module is an error forcing fallback
// - commanded stop or reset state change forces fallback
// - every fallback stops the heartbeat message
// - in normal operation the heartbeat is sent periodically
package ibcc_pkg;
    localparam int          CLK_HZ         = 125_000_000;
    localparam int          HOLD_MS        = 2000;
    localparam int          HOLD_CYCLES    = (CLK_HZ / 1000) * HOLD_MS;
    localparam int          HB_PERIOD_US   = 1000;
    localparam int          HB_PERIOD_CYC  = (CLK_HZ / 1_000_000) * HB_PERIOD_US;
    localparam int          HB_TIMEOUT_CYC = 4 * HB_PERIOD_CYC;
    localparam logic [6:0]  UNIT_ADDR      = 7'h7f;
    localparam logic [6:0]  FIRST_ADDR     = 7'h01;
    localparam logic [6:0]  LAST_ADDR      = 7'h0c;
    localparam logic [6:0]  NO_ADDR        = 7'h00;
    localparam int          MAX_SLOTS      = 16;
    localparam int          MAX_MODS       = 12;
    localparam logic [1:0]  SLOT_EMPTY     = 2'h0;
    localparam logic [1:0]  SLOT_IO        = 2'h1;
    localparam logic [1:0]  SLOT_PASSIVE   = 2'h2;
    localparam logic [1:0]  SLOT_END       = 2'h3;
    localparam logic [15:0] FALLBACK_VALUE = 16'h0000;

    typedef enum logic [3:0] {
        IBCC_IDLE, IBCC_ADDR, IBCC_CHECK, IBCC_NVM, IBCC_INIT, IBCC_RUN, IBCC_FALLBACK
    } ibcc_state_t;

    // an address is only ever handed out inside the basic window
    function automatic logic ibcc_addr_ok(input logic [6:0] a);
        return (a >= FIRST_ADDR) && (a <= LAST_ADDR);
    endfunction
endpackage

// [ibcc_hold_timer.sv]
`timescale 1ns/1ps
// button hold qualifier: one pulse once held continuously long enough
module ibcc_hold_timer #(
    parameter int HOLD_CYC = ibcc_pkg::HOLD_CYCLES
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic btn_level,
    output logic      hold_pulse
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        fired_r;
    logic        fired_nxt;

    // released button restarts the count, so brief presses never fire
    always_comb begin
        cnt_nxt    = cnt_r;
        fired_nxt  = fired_r;
        hold_pulse = 1'b0;
        if (!btn_level) begin
            cnt_nxt   = '0;
            fired_nxt = 1'b0;
        end else if (!fired_r) begin
            if (cnt_r >= 32'(HOLD_CYC - 1)) begin
                hold_pulse = 1'b1;
                fired_nxt  = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r   <= '0;
            fired_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            fired_r <= fired_nxt;
        end
    end
endmodule

// [ibcc_heartbeat.sv]
`timescale 1ns/1ps
// periodic heartbeat source and module heartbeat watchdog
module ibcc_heartbeat #(
    parameter int PERIOD_CYC  = ibcc_pkg::HB_PERIOD_CYC,
    parameter int TIMEOUT_CYC = ibcc_pkg::HB_TIMEOUT_CYC
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic enable,
    input  wire logic peer_beat,
    output logic      beat_out,
    output logic      beat_lost
);
    logic [31:0] per_r;
    logic [31:0] per_nxt;
    logic [31:0] wd_r;
    logic [31:0] wd_nxt;
    logic        beat_r;
    logic        beat_nxt;

    // sender and watchdog both stop when disabled so a fresh run starts clean
    always_comb begin
        per_nxt  = per_r;
        wd_nxt   = wd_r;
        beat_nxt = 1'b0;
        if (!enable) begin
            per_nxt = '0;
            wd_nxt  = '0;
        end else begin
            if (per_r >= 32'(PERIOD_CYC - 1)) begin
                per_nxt  = '0;
                beat_nxt = 1'b1;
            end else begin
                per_nxt = per_r + 32'h0000_0001;
            end
            if (peer_beat) begin
                wd_nxt = '0;
            end else if (wd_r < 32'(TIMEOUT_CYC)) begin
                wd_nxt = wd_r + 32'h0000_0001;
            end
        end
    end

    // a beat launched on the edge that drops enable must not leak into fallback
    assign beat_out  = beat_r && enable;
    assign beat_lost = enable && (wd_r >= 32'(TIMEOUT_CYC));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            per_r  <= '0;
            wd_r   <= '0;
            beat_r <= 1'b0;
        end else begin
            per_r  <= per_nxt;
            wd_r   <= wd_nxt;
            beat_r <= beat_nxt;
        end
    end
endmodule

// [ibcc_top.sv]
`timescale 1ns/1ps
// island bus configuration controller of the network interface unit
module ibcc_top #(
    parameter int HOLD_CYC    = ibcc_pkg::HOLD_CYCLES,
    parameter int PERIOD_CYC  = ibcc_pkg::HB_PERIOD_CYC,
    parameter int TIMEOUT_CYC = ibcc_pkg::HB_TIMEOUT_CYC
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        reconfig_btn,
    input  wire logic        nvm_valid,
    input  wire logic        fieldbus_ok,
    input  wire logic        stop_cmd,
    input  wire logic [1:0]  slot_type,
    input  wire logic        slot_connected,
    input  wire logic        module_beat,
    input  wire logic        nvm_ready,
    output logic [3:0]       slot_sel,
    output logic             addr_wr,
    output logic [6:0]       addr_val,
    output logic [6:0]       unit_addr,
    output logic             nvm_wr,
    output logic [6:0]       nvm_addr,
    output logic             nvm_done,
    output logic             heartbeat,
    output logic             fallback,
    output logic [15:0]      out_force_value,
    output logic             configured,
    output logic             config_error,
    output logic             running,
    output logic [3:0]       module_count
);
    // button and fieldbus status arrive from outside: two flops each
    logic [1:0] btn_sync_r;
    logic [1:0] fb_sync_r;
    logic [1:0] beat_sync_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            btn_sync_r  <= 2'b00;
            fb_sync_r   <= 2'b00;
            beat_sync_r <= 2'b00;
        end else begin
            btn_sync_r  <= {btn_sync_r[0], reconfig_btn};
            fb_sync_r   <= {fb_sync_r[0], fieldbus_ok};
            beat_sync_r <= {beat_sync_r[0], module_beat};
        end
    end

    logic hold_pulse;
    logic hb_en;
    logic beat_lost;
    logic beat_q_r;

    ibcc_hold_timer #(.HOLD_CYC(HOLD_CYC)) u_hold (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .btn_level  (btn_sync_r[1]),
        .hold_pulse (hold_pulse)
    );

    // edge of the synchronised module beat counts as one arrival
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            beat_q_r <= 1'b0;
        end else begin
            beat_q_r <= beat_sync_r[1];
        end
    end

    ibcc_heartbeat #(.PERIOD_CYC(PERIOD_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_hb (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .enable    (hb_en),
        .peer_beat (beat_sync_r[1] && !beat_q_r),
        .beat_out  (heartbeat),
        .beat_lost (beat_lost)
    );

    ibcc_pkg::ibcc_state_t st_r;
    ibcc_pkg::ibcc_state_t st_nxt;
    logic [3:0]  slot_r;
    logic [3:0]  slot_nxt;
    logic [6:0]  next_addr_r;
    logic [6:0]  next_addr_nxt;
    logic [6:0]  nvm_idx_r;
    logic [6:0]  nvm_idx_nxt;
    logic        write_nvm_r;
    logic        write_nvm_nxt;
    logic        cfg_ok_r;
    logic        cfg_ok_nxt;
    logic        err_r;
    logic        err_nxt;
    logic        addr_wr_r;
    logic        addr_wr_nxt;
    logic [6:0]  addr_val_r;
    logic [6:0]  addr_val_nxt;
    logic        nvm_wr_r;
    logic        nvm_wr_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        fb_hold_r;
    logic        fb_hold_nxt;

    logic fault;
    // any fallback cause, checked while running
    assign fault = !fb_sync_r[1] || beat_lost || stop_cmd;

    // configuration sequencer: address walk, connection check, nvm write, init
    always_comb begin
        st_nxt        = st_r;
        slot_nxt      = slot_r;
        next_addr_nxt = next_addr_r;
        nvm_idx_nxt   = nvm_idx_r;
        write_nvm_nxt = write_nvm_r;
        cfg_ok_nxt    = cfg_ok_r;
        err_nxt       = err_r;
        addr_wr_nxt   = 1'b0;
        addr_val_nxt  = addr_val_r;
        nvm_wr_nxt    = 1'b0;
        done_nxt      = 1'b0;
        fb_hold_nxt   = fb_hold_r;
        case (st_r)
            ibcc_pkg::IBCC_IDLE: begin
                // first power-up has no stored config: store defaults then
                write_nvm_nxt = !nvm_valid;
                slot_nxt      = '0;
                next_addr_nxt = ibcc_pkg::FIRST_ADDR;
                err_nxt       = 1'b0;
                st_nxt        = ibcc_pkg::IBCC_ADDR;
            end
            ibcc_pkg::IBCC_ADDR: begin
                // walk slots left to right; passive slots consume nothing
                if (slot_type == ibcc_pkg::SLOT_END ||
                    slot_r == 4'(ibcc_pkg::MAX_SLOTS - 1)) begin
                    slot_nxt = '0;
                    st_nxt   = ibcc_pkg::IBCC_CHECK;
                end else begin
                    if (slot_type == ibcc_pkg::SLOT_IO) begin
                        if (ibcc_pkg::ibcc_addr_ok(next_addr_r)) begin
                            addr_wr_nxt   = 1'b1;
                            addr_val_nxt  = next_addr_r;
                            next_addr_nxt = next_addr_r + 7'h01;
                        end else begin
                            err_nxt = 1'b1; // too many modules: never reuse an address
                        end
                    end
                    slot_nxt = slot_r + 4'h1;
                end
            end
            ibcc_pkg::IBCC_CHECK: begin
                // every addressed module must report a good backplane contact
                if (32'(slot_r) + 1 >= 32'(next_addr_r)) begin
                    nvm_idx_nxt = ibcc_pkg::FIRST_ADDR;
                    st_nxt = write_nvm_r ? ibcc_pkg::IBCC_NVM : ibcc_pkg::IBCC_INIT;
                end else begin
                    if (!slot_connected) begin
                        err_nxt = 1'b1;
                    end
                    slot_nxt = slot_r + 4'h1;
                end
            end
            ibcc_pkg::IBCC_NVM: begin
                // defaults of each module overwrite stored config, one per ready
                if (nvm_idx_r >= next_addr_r) begin
                    done_nxt = 1'b1;
                    st_nxt   = ibcc_pkg::IBCC_INIT;
                end else if (nvm_ready && !nvm_wr_r) begin
                    nvm_wr_nxt  = 1'b1;
                    nvm_idx_nxt = nvm_idx_r + 7'h01;
                end
            end
            ibcc_pkg::IBCC_INIT: begin
                // a faulty pass does not count as a successful configuration
                if (err_r) begin
                    fb_hold_nxt = 1'b1;
                    st_nxt      = ibcc_pkg::IBCC_FALLBACK;
                end else begin
                    cfg_ok_nxt  = 1'b1;
                    fb_hold_nxt = 1'b0;
                    st_nxt      = ibcc_pkg::IBCC_RUN;
                end
            end
            ibcc_pkg::IBCC_RUN: begin
                if (hold_pulse && cfg_ok_r) begin
                    write_nvm_nxt = 1'b1;
                    slot_nxt      = '0;
                    next_addr_nxt = ibcc_pkg::FIRST_ADDR;
                    err_nxt       = 1'b0;
                    fb_hold_nxt   = 1'b1;
                    st_nxt        = ibcc_pkg::IBCC_ADDR;
                end else if (fault) begin
                    fb_hold_nxt = 1'b1;
                    st_nxt      = ibcc_pkg::IBCC_FALLBACK;
                end
            end
            ibcc_pkg::IBCC_FALLBACK: begin
                // leave fallback only by reconfiguration or backplane reset
                if (hold_pulse && cfg_ok_r) begin
                    write_nvm_nxt = 1'b1;
                    slot_nxt      = '0;
                    next_addr_nxt = ibcc_pkg::FIRST_ADDR;
                    err_nxt       = 1'b0;
                    st_nxt        = ibcc_pkg::IBCC_ADDR;
                end
            end
            default: begin
                st_nxt = ibcc_pkg::IBCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r        <= ibcc_pkg::IBCC_IDLE;
            slot_r      <= '0;
            next_addr_r <= ibcc_pkg::FIRST_ADDR;
            nvm_idx_r   <= ibcc_pkg::FIRST_ADDR;
            write_nvm_r <= 1'b0;
            cfg_ok_r    <= 1'b0;
            err_r       <= 1'b0;
            addr_wr_r   <= 1'b0;
            addr_val_r  <= ibcc_pkg::NO_ADDR;
            nvm_wr_r    <= 1'b0;
            done_r      <= 1'b0;
            fb_hold_r   <= 1'b1;
        end else begin
            st_r        <= st_nxt;
            slot_r      <= slot_nxt;
            next_addr_r <= next_addr_nxt;
            nvm_idx_r   <= nvm_idx_nxt;
            write_nvm_r <= write_nvm_nxt;
            cfg_ok_r    <= cfg_ok_nxt;
            err_r       <= err_nxt;
            addr_wr_r   <= addr_wr_nxt;
            addr_val_r  <= addr_val_nxt;
            nvm_wr_r    <= nvm_wr_nxt;
            done_r      <= done_nxt;
            fb_hold_r   <= fb_hold_nxt;
        end
    end

    // heartbeat only while running and the registered fallback flag is clear
    assign hb_en = (st_r == ibcc_pkg::IBCC_RUN) && !fb_hold_r;

    // fieldbus baud and node id live elsewhere; nothing here can write them
    assign slot_sel        = slot_r;
    assign addr_wr         = addr_wr_r;
    assign addr_val        = addr_val_r;
    assign unit_addr       = ibcc_pkg::UNIT_ADDR;
    assign nvm_wr          = nvm_wr_r;
    assign nvm_addr        = nvm_idx_r - 7'h01;
    assign nvm_done        = done_r;
    assign fallback        = fb_hold_r;
    // fixed constant, no port can alter it
    assign out_force_value = ibcc_pkg::FALLBACK_VALUE;
    assign configured      = cfg_ok_r;
    assign config_error    = err_r;
    assign running         = (st_r == ibcc_pkg::IBCC_RUN);
    assign module_count    = 4'(next_addr_r - ibcc_pkg::FIRST_ADDR);
endmodule

// [ibcc_island_model.sv]
`timescale 1ns/1ps
// backplane side: slot table, module beats and a flash that stalls now and then
module ibcc_island_model (
    input  wire logic       mclk,
    input  wire logic [3:0] slot_sel,
    input  wire logic       beat_en,
    output logic [1:0]      slot_type,
    output logic            slot_connected,
    output logic            module_beat,
    output logic            nvm_ready
);
    logic [1:0] slots [16];
    logic [3:0] beat_cnt_r;
    logic       conn_ok;

    // the walk reads the table combinationally; passive slots answer as such
    assign slot_type      = slots[slot_sel];
    assign slot_connected = conn_ok;

    initial begin
        beat_cnt_r  = 4'h0;
        conn_ok     = 1'b1;
        module_beat = 1'b0;
        nvm_ready   = 1'b1;
        foreach (slots[i]) slots[i] = 2'h3;
    end

    // a beat every 8 cycles; beat_en low models a dead module
    always @(posedge mclk) begin
        beat_cnt_r  <= beat_cnt_r + 4'h1;
        module_beat <= beat_en && (beat_cnt_r[2:0] == 3'h0);
        nvm_ready   <= ($urandom_range(0, 3) != 0);
    end
endmodule

// [ibcc_top_assertions.sv]
`timescale 1ns/1ps
// port-level checks on addressing, fallback and heartbeat timing
module ibcc_top_assertions #(
    parameter int HOLD_CYC    = 20,
    parameter int PERIOD_CYC  = 8,
    parameter int TIMEOUT_CYC = 32
) (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        fieldbus_ok,
    input wire logic        stop_cmd,
    input wire logic        module_beat,
    input wire logic        addr_wr,
    input wire logic [6:0]  addr_val,
    input wire logic [6:0]  unit_addr,
    input wire logic        nvm_done,
    input wire logic        heartbeat,
    input wire logic        fallback,
    input wire logic [15:0] out_force_value,
    input wire logic        config_error,
    input wire logic        running
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic [6:0] prev_r, prev_nxt;
    logic [7:0] gap_r, gap_nxt, bgap_r, bgap_nxt;
    logic       seen_r, seen_nxt;

    // gap counters saturate so a long silence cannot wrap back to legal
    always_comb begin
        prev_nxt = addr_wr ? addr_val : prev_r;
        gap_nxt  = heartbeat ? 8'h00 : gap_r + {7'h00, gap_r != 8'hff};
        seen_nxt = !fallback && (heartbeat || seen_r);
        bgap_nxt = (module_beat || !running) ? 8'h00 : bgap_r + {7'h00, bgap_r != 8'hff};
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_r <= 7'h00;
            gap_r  <= 8'h00;
            seen_r <= 1'b0;
            bgap_r <= 8'h00;
        end else begin
            prev_r <= prev_nxt;
            gap_r  <= gap_nxt;
            seen_r <= seen_nxt;
            bgap_r <= bgap_nxt;
        end
    end

    property p_unit; unit_addr == 7'h7f; endproperty
    a_unit: assert property (p_unit) else $error("unit address moved");
    property p_zero; out_force_value == 16'h0000; endproperty
    a_zero: assert property (p_zero) else $error("fallback value not zero");
    property p_rng; addr_wr |-> addr_val >= 7'h01 && addr_val <= 7'h0c; endproperty
    a_rng: assert property (p_rng) else $error("address out of range");
    property p_seq; addr_wr && addr_val != 7'h01 |-> addr_val == prev_r + 7'h01; endproperty
    a_seq: assert property (p_seq) else $error("address not consecutive");
    property p_hb_stop; fallback |-> !heartbeat; endproperty
    a_hb_stop: assert property (p_hb_stop) else $error("beat during fallback");
    property p_hb_gap; heartbeat && seen_r |-> gap_r == PERIOD_CYC - 1; endproperty
    a_hb_gap: assert property (p_hb_gap) else $error("beat period wrong");
    property p_hb_alive; seen_r && !fallback |-> gap_r < PERIOD_CYC + 1; endproperty
    a_hb_alive: assert property (p_hb_alive) else $error("beat missing");
    property p_fbus; !fieldbus_ok [*4] |-> ##[0:2] fallback; endproperty
    a_fbus: assert property (p_fbus) else $error("no fallback on link loss");
    property p_stop; stop_cmd |-> ##[1:2] fallback; endproperty
    a_stop: assert property (p_stop) else $error("no fallback on stop");
    property p_beat; running |-> bgap_r < TIMEOUT_CYC + 8; endproperty
    a_beat: assert property (p_beat) else $error("no fallback on beat loss");
    property p_done_run; nvm_done |-> ##[1:40] running; endproperty
    a_done_run: assert property (p_done_run) else $error("no run after store");

    c_beat: cover property (heartbeat);
    c_store: cover property (nvm_done);
    c_error: cover property (config_error);
endmodule

bind ibcc_top ibcc_top_assertions #(
    .HOLD_CYC(HOLD_CYC), .PERIOD_CYC(PERIOD_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)
) u_ibcc_top_assertions (
    .mclk(mclk), .sys_rst(sys_rst), .fieldbus_ok(fieldbus_ok), .stop_cmd(stop_cmd),
    .module_beat(module_beat), .addr_wr(addr_wr), .addr_val(addr_val),
    .unit_addr(unit_addr), .nvm_done(nvm_done), .heartbeat(heartbeat),
    .fallback(fallback), .out_force_value(out_force_value),
    .config_error(config_error), .running(running)
);

// [test_island_bus_config_controller.sv]
`timescale 1ns/1ps
// bench: random island walks, reconfiguration, fallback causes, refused presses
module test_island_bus_config_controller;
    logic mclk = 1'b0, sys_rst = 1'b1, reconfig_btn = 1'b0, nvm_valid = 1'b0;
    logic fieldbus_ok = 1'b1, stop_cmd = 1'b0, beat_en = 1'b1;
    logic [1:0] slot_type;
    logic slot_connected, module_beat, nvm_ready, addr_wr, nvm_wr, nvm_done;
    logic heartbeat, fallback, configured, config_error, running;
    logic [3:0] slot_sel, module_count;
    logic [6:0] addr_val, unit_addr, nvm_addr;
    logic [15:0] out_force_value;
    int fails = 0, compares = 0, nwr = 0, hbc = 0, n;
    logic [6:0] exp_q [$];

    always #4 mclk = ~mclk;

    ibcc_top #(.HOLD_CYC(20), .PERIOD_CYC(8), .TIMEOUT_CYC(32)) u_ibcc_top (
        .mclk(mclk), .sys_rst(sys_rst), .reconfig_btn(reconfig_btn),
        .nvm_valid(nvm_valid), .fieldbus_ok(fieldbus_ok), .stop_cmd(stop_cmd),
        .slot_type(slot_type), .slot_connected(slot_connected),
        .module_beat(module_beat), .nvm_ready(nvm_ready), .slot_sel(slot_sel),
        .addr_wr(addr_wr), .addr_val(addr_val), .unit_addr(unit_addr),
        .nvm_wr(nvm_wr), .nvm_addr(nvm_addr), .nvm_done(nvm_done),
        .heartbeat(heartbeat), .fallback(fallback), .out_force_value(out_force_value),
        .configured(configured), .config_error(config_error), .running(running),
        .module_count(module_count));
    ibcc_island_model u_ibcc_island_model (
        .mclk(mclk), .slot_sel(slot_sel), .beat_en(beat_en), .slot_type(slot_type),
        .slot_connected(slot_connected), .module_beat(module_beat),
        .nvm_ready(nvm_ready));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watcher: each address write takes the oldest note; extras always mismatch
    always @(posedge mclk) begin
        if (addr_wr === 1'b1) begin
            if (exp_q.size() == 0) check({9'h000, addr_val}, 16'hffff);
            else check({9'h000, addr_val}, {9'h000, exp_q.pop_front()});
        end
        if (nvm_wr === 1'b1) nwr++;
        if (heartbeat === 1'b1) hbc++;
    end

    // random island; the order of io slots fixes the expected addresses
    task automatic load(input int cnt);
        int k;
        k = 0;
        for (int s = 0; s < 16; s++) begin
            if (k == cnt || s == 15) u_ibcc_island_model.slots[s] = 2'h3;
            else if (15 - s > cnt - k && $urandom_range(0, 2) == 0)
                u_ibcc_island_model.slots[s] = $urandom_range(0, 1) ? 2'h2 : 2'h0;
            else begin
                u_ibcc_island_model.slots[s] = 2'h1;
                k++;
                if (k <= 12) exp_q.push_back(7'(k));
            end
        end
    endtask

    task automatic do_reset(input logic first, input int cnt);
        @(posedge mclk);
        sys_rst <= 1'b1;
        nvm_valid <= ~first;
        load(cnt);
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
    endtask

    // bounded wait: 0 run, 1 fallback; a timeout is a mismatch
    task automatic wait_on(input int which, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge mclk);
            #1;
            if (which == 0 && running === 1'b1 && fallback === 1'b0) break;
            if (which == 1 && fallback === 1'b1) break;
        end
        check({15'h0000, i < lim}, 16'h0001);
    endtask

    task automatic press(input int cyc);
        @(posedge mclk);
        reconfig_btn <= 1'b1;
        repeat (cyc) @(posedge mclk);
        reconfig_btn <= 1'b0;
    endtask

    initial begin
        void'($urandom(23));
        // first power-up stores defaults for every module
        do_reset(1'b1, 8);
        wait_on(0, 400);
        check(16'(nwr), 16'h0008);
        check(16'(module_count), 16'h0008);
        repeat (20) @(posedge mclk);
        check(16'(hbc > 1), 16'h0001);
        // later resets re-address but keep the stored configuration
        for (int r = 0; r < 3; r++) begin
            n = $urandom_range(1, 12);
            nwr = 0;
            do_reset(1'b0, n);
            wait_on(0, 400);
            check(16'(nwr), 16'h0000);
            check(16'(module_count), 16'(n));
            check(16'(exp_q.size()), 16'h0000);
        end
        // each fallback cause, a too-short press, then a full reconfiguration
        for (int f = 0; f < 3; f++) begin
            @(posedge mclk);
            if (f == 0) fieldbus_ok <= 1'b0;
            if (f == 1) stop_cmd <= 1'b1;
            if (f == 2) beat_en <= 1'b0;
            wait_on(1, 60);
            repeat (2) @(posedge mclk);
            hbc = 0;
            fieldbus_ok <= 1'b1;
            stop_cmd <= 1'b0;
            beat_en <= 1'b1;
            press(12);
            repeat (40) @(posedge mclk);
            check(16'(hbc), 16'h0000);
            check(16'(fallback), 16'h0001);
            for (int k = 1; k <= n; k++) exp_q.push_back(7'(k));
            nwr = 0;
            press(30);
            wait_on(0, 600);
            check(16'(nwr), 16'(n));
            check(16'(exp_q.size()), 16'h0000);
        end
        // a loose module contact must spoil the pass
        u_ibcc_island_model.conn_ok = 1'b0;
        do_reset(1'b0, 4);
        repeat (60) @(posedge mclk);
        check(16'(config_error), 16'h0001);
        check(16'(running), 16'h0000);
        u_ibcc_island_model.conn_ok = 1'b1;
        // thirteen modules: twelve addresses, error, and the button is refused
        nwr = 0;
        do_reset(1'b0, 13);
        repeat (80) @(posedge mclk);
        check(16'(config_error), 16'h0001);
        check(16'(exp_q.size()), 16'h0000);
        press(30);
        repeat (60) @(posedge mclk);
        check(16'(configured), 16'h0000);
        check(16'(nwr), 16'h0000);
        tally_and_finish();
    end

    // the run needs about a thousand cycles; this cuts off a hang well past that
    initial begin
        #400_000;
        fails++;
        tally_and_finish();
    end
endmodule
